// ---- verilog/sesc_pkg.sv ----
// shared constants, command codes and defaults of the standard event status block
package sesc_pkg;
  // ***************************************************************
  // event register / enable mask layout
  // ***************************************************************
  localparam int EV_W = 8;
  localparam int BIT_POWERUP = 7;
  localparam int BIT_CMD_ERR = 5;
  localparam int BIT_EXE_ERR = 4;
  localparam int BIT_DEV_ERR = 3;
  localparam int BIT_QRY_ERR = 2;
  localparam int BIT_OP_DONE = 0;
  // bits 6 and 1 never store
  localparam logic [7:0] EV_IMPL_MASK = 8'hbd;
  localparam logic [7:0] EV_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;

  // ***************************************************************
  // status byte layout
  // ***************************************************************
  localparam int STB_OPER = 7;
  localparam int STB_SRQ = 6;
  localparam int STB_ESB = 5;
  localparam int STB_MAV = 4;
  localparam int STB_QUES = 3;

  // ***************************************************************
  // answers
  // ***************************************************************
  localparam logic [7:0] ASCII_ONE = 8'h31;
  localparam int IDN_FIELDS = 4;
  localparam logic [1:0] IDN_LAST = 2'h3;
  localparam logic [1:0] LOC_POWERUP = 2'h0;

  // ***************************************************************
  // factory defaults
  // ***************************************************************
  localparam logic [15:0] DEF_SWEEP_POINTS = 16'h0800;
  // sample interval in nanoseconds (15.6 us)
  localparam int SAMPLE_INTERVAL_NS = 15600;
  localparam logic [15:0] DEF_SAMPLE_NS = 16'(SAMPLE_INTERVAL_NS);
  localparam logic [7:0] DEF_TRIG_COUNT = 8'h01;
  localparam logic [15:0] DEF_TRIG_LEVEL = 16'h0000;
  localparam logic [15:0] DEF_TRIG_HYST = 16'h0000;

  typedef enum logic [3:0] {
    SESC_CMD_ESE_WR,
    SESC_CMD_ESE_RD,
    SESC_CMD_ESR_RD,
    SESC_CMD_SRE_WR,
    SESC_CMD_SRE_RD,
    SESC_CMD_STB_RD,
    SESC_CMD_CLS,
    SESC_CMD_OPC,
    SESC_CMD_OPC_RD,
    SESC_CMD_IDN_RD,
    SESC_CMD_OPT_RD,
    SESC_CMD_PSC_WR,
    SESC_CMD_PSC_RD,
    SESC_CMD_RECALL,
    SESC_CMD_FACTORY,
    SESC_CMD_OTHER
  } sesc_cmd_t;
endpackage

// ---- verilog/sesc_pending.sv ----
// tracker of outstanding overlapped operations and triggered actions
`timescale 1ns/100ps
module sesc_pending
  import sesc_pkg::*;
#(
  parameter int CNT_W = 6
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic op_start,
  input wire logic op_done,
  input wire logic trig_busy,
  input wire logic abort,
  output logic all_done
);
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;

  always_comb
  begin
    count_next = count_reg;
    // abort cancels unfinished overlapped work; trig_busy still holds all_done low
    if (abort)
      count_next = '0;
    else if (op_start && !op_done)
      count_next = count_reg + 1'b1;
    else if (op_done && !op_start && count_reg != '0)
      count_next = count_reg - 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      count_reg <= '0;
    else
      count_reg <= count_next;
  end

  // a start in this cycle counts as pending already
  assign all_done = (count_reg == '0) && !op_start && !trig_busy; // (R7)
endmodule

// ---- verilog/sesc_status_block.sv ----
// standard event status block: event flags, masks, completion, identity and reset
`timescale 1ns/100ps
// Contract
// (R1) enable mask bit one lets matching event flag reach the summary
// (R2) event summary bit is OR of enabled event flags
// (R3) eight-bit layout shared by flags and mask; bits 6 and 1 read zero
// (R4) host writes mask 0..255; query returns current mask
// (R5) reading event flags returns value then clears them
// (R6) completion command keeps accepting; sets bit 0 when pending work ends
// (R7) pending work ends when overlapped commands and triggers finish
// (R8) output, relay and trigger commands overlap; others finish first
// (R9) completion query stalls commands, then queues ASCII one
// (R10) identity query returns four fields in fixed order
// (R11) option query reports options by number, zero if none
// (R12) power-up clear on: both masks cleared at power-on
// (R13) power-up clear off: masks restored from nonvolatile store
// (R14) mask write with clear off, and clear setting change, write store
// (R15) recall forces trigger abort, cancelling trigger actions
// (R16) recall leaves calibration disabled
// (R17) power-on recalls location 0 when selected
// (R18) factory reset forces trigger abort
// (R19) factory reset loads fixed defaults
// (R20) service-request-enabled status bits ORed into bit 6
// (R21) clear-status clears event flags and other status
// (R22) summary recomputed combinationally from flags and mask
// (R23) event flags sticky until read or clear-status
module sesc_status_block
  import sesc_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h4d, // arbitrary value
  parameter logic [7:0] MODEL_CODE = 8'h41, // arbitrary value
  parameter logic [7:0] SERIAL_CODE = 8'h00,
  parameter logic [7:0] FW_REV_CODE = 8'h10, // arbitrary value
  parameter logic [7:0] OPTION_CODE = 8'h00,
  parameter int PEND_W = 6
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire sesc_cmd_t cmd_code,
  input wire logic cmd_overlap,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  output logic resp_valid,
  output logic [7:0] resp_data,
  output logic resp_last,
  input wire logic op_done,
  input wire logic trig_busy,
  input wire logic command_error_flag,
  input wire logic execution_error_flag,
  input wire logic device_error_flag,
  input wire logic query_error_flag,
  input wire logic oper_summary,
  input wire logic ques_summary,
  input wire logic msg_available,
  input wire logic nv_powerup_clear,
  input wire logic [7:0] nv_event_mask,
  input wire logic [7:0] nv_service_mask,
  input wire logic powerup_state_select,
  output logic nv_write,
  output logic [7:0] nv_event_mask_out,
  output logic [7:0] nv_service_mask_out,
  output logic nv_powerup_clear_out,
  output logic event_summary_bit,
  output logic [7:0] status_byte,
  output logic service_request,
  output logic status_clear,
  output logic trigger_abort,
  output logic state_recall,
  output logic [1:0] recall_location,
  output logic cal_disable,
  output logic factory_load,
  output logic [15:0] sweep_points,
  output logic [15:0] sample_interval_ns,
  output logic acq_source_internal,
  output logic tran_source_bus,
  output logic slope_positive,
  output logic [7:0] trigger_count,
  output logic [15:0] trigger_level,
  output logic [15:0] trigger_hyst
);
  // ***************************************************************
  // state
  // ***************************************************************
  typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_OPCQ, ST_IDN} sesc_state_t;

  sesc_state_t state_reg, state_next;
  logic [7:0] event_flags_reg, event_flags_next;
  logic [7:0] event_enable_mask_reg, event_enable_mask_next;
  logic [7:0] service_request_mask_reg, service_request_mask_next;
  logic powerup_clear_setting_reg, powerup_clear_setting_next;
  logic opc_armed_reg, opc_armed_next;
  logic [1:0] idn_idx_reg, idn_idx_next;
  logic resp_valid_reg, resp_valid_next;
  logic [7:0] resp_data_reg, resp_data_next;
  logic resp_last_reg, resp_last_next;
  logic nv_write_reg, nv_write_next, clear_reg, clear_next, abort_reg, abort_next, recall_reg, recall_next;
  logic [1:0] loc_reg, loc_next;
  logic cal_dis_reg, cal_dis_next, factory_reg, factory_next, defaults_reg, defaults_next, take, all_done;
  logic [7:0] ev_set;
  logic [7:0] stb_raw;

  assign take = cmd_valid && cmd_ready;

  sesc_pending #(.CNT_W(PEND_W)) u_pending (
    .clock(clock),
    .rst(rst),
    .op_start(take && cmd_overlap), // (R8)
    .op_done(op_done),
    .trig_busy(trig_busy),
    .abort(abort_next),
    .all_done(all_done)
  );

  // ***************************************************************
  // summaries
  // ***************************************************************
  assign event_summary_bit = |(event_flags_reg & event_enable_mask_reg); // (R1) (R2) (R22)
  assign stb_raw = {oper_summary, 1'b0, event_summary_bit, msg_available, ques_summary, 3'b000};
  assign service_request = |(stb_raw & service_request_mask_reg); // (R20)
  assign status_byte = {stb_raw[7], service_request, stb_raw[5:0]};
  // only idle takes commands; a completion query holds them off
  assign cmd_ready = (state_reg == ST_IDLE); // (R6) (R8) (R9)

  // ***************************************************************
  // next-state logic
  // ***************************************************************
  always_comb
  begin
    state_next = state_reg;
    event_enable_mask_next = event_enable_mask_reg;
    service_request_mask_next = service_request_mask_reg;
    powerup_clear_setting_next = powerup_clear_setting_reg;
    opc_armed_next = opc_armed_reg;
    idn_idx_next = idn_idx_reg;
    resp_valid_next = 1'b0;
    resp_data_next = resp_data_reg;
    resp_last_next = 1'b0;
    nv_write_next = 1'b0;
    clear_next = 1'b0;
    abort_next = 1'b0;
    recall_next = 1'b0;
    loc_next = loc_reg;
    cal_dis_next = cal_dis_reg;
    factory_next = 1'b0;
    defaults_next = 1'b0;
    event_flags_next = event_flags_reg;
    ev_set = 8'h00;
    ev_set[BIT_CMD_ERR] = command_error_flag;
    ev_set[BIT_EXE_ERR] = execution_error_flag;
    ev_set[BIT_DEV_ERR] = device_error_flag;
    ev_set[BIT_QRY_ERR] = query_error_flag;
    if (opc_armed_reg && all_done)
    begin
      ev_set[BIT_OP_DONE] = 1'b1; // (R6) (R7)
      opc_armed_next = 1'b0;
    end
    case (state_reg)
      ST_INIT:
      begin
        ev_set[BIT_POWERUP] = 1'b1;
        powerup_clear_setting_next = nv_powerup_clear;
        if (nv_powerup_clear)
        begin
          event_enable_mask_next = MASK_RESET; // (R12)
          service_request_mask_next = MASK_RESET; // (R12)
        end
        else
        begin
          event_enable_mask_next = nv_event_mask & EV_IMPL_MASK; // (R13)
          service_request_mask_next = nv_service_mask; // (R13)
        end
        if (powerup_state_select)
        begin
          recall_next = 1'b1; // (R17)
          loc_next = LOC_POWERUP; // (R17)
          abort_next = 1'b1; // (R15)
          cal_dis_next = 1'b1; // (R16)
        end
        state_next = ST_IDLE;
      end
      ST_IDLE:
      begin
        if (take)
        begin
          case (cmd_code)
            SESC_CMD_ESE_WR:
            begin
              event_enable_mask_next = cmd_data & EV_IMPL_MASK; // (R3) (R4)
              nv_write_next = !powerup_clear_setting_reg; // (R14)
            end
            SESC_CMD_ESE_RD:
            begin
              resp_valid_next = 1'b1;
              resp_data_next = event_enable_mask_reg; // (R4)
            end
            SESC_CMD_ESR_RD:
            begin
              resp_valid_next = 1'b1;
              resp_data_next = event_flags_reg & EV_IMPL_MASK; // (R3) (R5)
              event_flags_next = EV_RESET; // (R5)
            end
            SESC_CMD_SRE_WR:
            begin
              service_request_mask_next = cmd_data;
              nv_write_next = !powerup_clear_setting_reg;
            end
            SESC_CMD_SRE_RD:
            begin
              resp_valid_next = 1'b1;
              resp_data_next = service_request_mask_reg;
            end
            SESC_CMD_STB_RD:
            begin
              resp_valid_next = 1'b1;
              resp_data_next = status_byte;
            end
            SESC_CMD_CLS:
            begin
              event_flags_next = EV_RESET; // (R21)
              clear_next = 1'b1; // (R21)
            end
            SESC_CMD_OPC:
              opc_armed_next = 1'b1; // (R6)
            SESC_CMD_OPC_RD:
              state_next = ST_OPCQ; // (R9)
            SESC_CMD_IDN_RD:
            begin
              idn_idx_next = 2'h0;
              state_next = ST_IDN;
            end
            SESC_CMD_OPT_RD:
            begin
              resp_valid_next = 1'b1;
              resp_data_next = OPTION_CODE; // (R11)
            end
            SESC_CMD_PSC_WR:
            begin
              powerup_clear_setting_next = cmd_data[0];
              nv_write_next = 1'b1; // (R14)
            end
            SESC_CMD_PSC_RD:
            begin
              resp_valid_next = 1'b1;
              resp_data_next = {7'h00, powerup_clear_setting_reg};
            end
            SESC_CMD_RECALL:
            begin
              recall_next = 1'b1;
              loc_next = cmd_data[1:0];
              abort_next = 1'b1; // (R15)
              cal_dis_next = 1'b1; // (R16)
            end
            SESC_CMD_FACTORY:
            begin
              factory_next = 1'b1;
              defaults_next = 1'b1; // (R19)
              abort_next = 1'b1; // (R18)
              cal_dis_next = 1'b1;
            end
            default: ;
          endcase
        end
      end
      ST_OPCQ:
      begin
        if (all_done)
        begin
          resp_valid_next = 1'b1;
          resp_data_next = ASCII_ONE; // (R9)
          state_next = ST_IDLE;
        end
      end
      ST_IDN:
      begin
        resp_valid_next = 1'b1;
        case (idn_idx_reg)
          2'h0: resp_data_next = MAKER_CODE; // (R10)
          2'h1: resp_data_next = MODEL_CODE;
          2'h2: resp_data_next = SERIAL_CODE;
          default: resp_data_next = FW_REV_CODE;
        endcase
        resp_last_next = (idn_idx_reg == IDN_LAST);
        idn_idx_next = idn_idx_reg + 2'h1;
        if (idn_idx_reg == IDN_LAST)
          state_next = ST_IDLE;
      end
      default:
        state_next = ST_IDLE;
    endcase
    // every answer but the identity stream is a single byte
    if (state_reg != ST_IDN)
      resp_last_next = resp_valid_next;
    // new events win over a read or clear in the same cycle
    event_flags_next = (event_flags_next | ev_set) & EV_IMPL_MASK; // (R3) (R23)
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_reg <= ST_INIT;
      event_flags_reg <= EV_RESET;
      event_enable_mask_reg <= MASK_RESET;
      service_request_mask_reg <= MASK_RESET;
      powerup_clear_setting_reg <= 1'b1;
      opc_armed_reg <= 1'b0;
      idn_idx_reg <= 2'h0;
      resp_valid_reg <= 1'b0;
      resp_data_reg <= 8'h00;
      resp_last_reg <= 1'b0;
      nv_write_reg <= 1'b0;
      clear_reg <= 1'b0;
      abort_reg <= 1'b0;
      recall_reg <= 1'b0;
      loc_reg <= 2'h0;
      cal_dis_reg <= 1'b0;
      factory_reg <= 1'b0;
      defaults_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      event_flags_reg <= event_flags_next;
      event_enable_mask_reg <= event_enable_mask_next;
      service_request_mask_reg <= service_request_mask_next;
      powerup_clear_setting_reg <= powerup_clear_setting_next;
      opc_armed_reg <= opc_armed_next;
      idn_idx_reg <= idn_idx_next;
      resp_valid_reg <= resp_valid_next;
      resp_data_reg <= resp_data_next;
      resp_last_reg <= resp_last_next;
      nv_write_reg <= nv_write_next;
      clear_reg <= clear_next;
      abort_reg <= abort_next;
      recall_reg <= recall_next;
      loc_reg <= loc_next;
      cal_dis_reg <= cal_dis_next;
      factory_reg <= factory_next;
      defaults_reg <= defaults_next;
    end
  end

  // ***************************************************************
  // factory settings
  // ***************************************************************
  // loaded after reset and on factory reset; nothing else writes them
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sweep_points <= 16'h0000;
      sample_interval_ns <= 16'h0000;
      acq_source_internal <= 1'b0;
      tran_source_bus <= 1'b0;
      slope_positive <= 1'b0;
      trigger_count <= 8'h00;
      trigger_level <= 16'h0000;
      trigger_hyst <= 16'h0000;
    end
    else if (defaults_reg)
    begin
      sweep_points <= DEF_SWEEP_POINTS; // (R19)
      sample_interval_ns <= DEF_SAMPLE_NS;
      acq_source_internal <= 1'b1;
      tran_source_bus <= 1'b1;
      slope_positive <= 1'b1;
      trigger_count <= DEF_TRIG_COUNT;
      trigger_level <= DEF_TRIG_LEVEL;
      trigger_hyst <= DEF_TRIG_HYST;
    end
  end

  assign resp_valid = resp_valid_reg;
  assign resp_data = resp_data_reg;
  assign resp_last = resp_last_reg;
  assign nv_write = nv_write_reg;
  assign nv_event_mask_out = event_enable_mask_reg;
  assign nv_service_mask_out = service_request_mask_reg;
  assign nv_powerup_clear_out = powerup_clear_setting_reg;
  assign status_clear = clear_reg;
  assign trigger_abort = abort_reg;
  assign state_recall = recall_reg;
  assign recall_location = loc_reg;
  assign cal_disable = cal_dis_reg;
  assign factory_load = factory_reg;
endmodule

// ---- bench/sesc_status_chk.sv ----
// port checker of the standard event status block
`timescale 1ns/100ps
module sesc_status_chk
  import sesc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire sesc_cmd_t cmd_code,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_ready,
  input wire logic resp_valid,
  input wire logic [7:0] resp_data,
  input wire logic resp_last,
  input wire logic oper_summary,
  input wire logic ques_summary,
  input wire logic msg_available,
  input wire logic nv_write,
  input wire logic [7:0] nv_event_mask_out,
  input wire logic [7:0] nv_service_mask_out,
  input wire logic nv_powerup_clear_out,
  input wire logic event_summary_bit,
  input wire logic [7:0] status_byte,
  input wire logic service_request,
  input wire logic trigger_abort,
  input wire logic state_recall,
  input wire logic [1:0] recall_location,
  input wire logic cal_disable,
  input wire logic factory_load,
  input wire logic [15:0] sweep_points
);
  // ***************************************************************
  // helpers and assertions
  // ***************************************************************
  logic [7:0] last_data_reg;
  logic take;
  assign take = cmd_valid && cmd_ready;
  always_ff @(posedge clock)
  begin
    last_data_reg <= cmd_data;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_esb_needs_mask: assert property (event_summary_bit |-> nv_event_mask_out != 8'h00)
    else $error("summary set with empty mask");
  chk_mask_zero_blocks: assert property (take && cmd_code == SESC_CMD_ESE_WR && cmd_data == 8'h00
    |=> !event_summary_bit) else $error("zero mask left summary set");
  chk_stb_layout: assert property (status_byte[2:0] == 3'h0 && status_byte[STB_ESB] == event_summary_bit
    && status_byte[STB_OPER] == oper_summary && status_byte[STB_MAV] == msg_available
    && status_byte[STB_QUES] == ques_summary) else $error("status byte layout wrong");
  chk_srq_or_bits: assert property (service_request == |(status_byte & nv_service_mask_out & 8'hbf)
    && status_byte[STB_SRQ] == service_request) else $error("service request summary wrong");
  chk_mask_write: assert property (take && cmd_code == SESC_CMD_ESE_WR
    |=> (nv_event_mask_out & EV_IMPL_MASK) == (last_data_reg & EV_IMPL_MASK)) else $error("mask not written");
  chk_nv_on_mask: assert property (take && cmd_code == SESC_CMD_ESE_WR && !nv_powerup_clear_out
    |=> nv_write) else $error("mask write skipped store");
  chk_nv_on_clear: assert property (take && cmd_code == SESC_CMD_PSC_WR
    |=> nv_write && nv_powerup_clear_out == last_data_reg[0]) else $error("clear setting not stored");
  chk_flag_read: assert property (take && cmd_code == SESC_CMD_ESR_RD
    |=> resp_valid && resp_last && (resp_data & 8'h42) == 8'h00) else $error("flag read answer wrong");
  chk_done_answer: assert property (take && cmd_code == SESC_CMD_OPC_RD
    |=> !cmd_ready ##[0:300] (resp_valid && resp_data == ASCII_ONE)) else $error("completion answer missing");
  chk_id_stream: assert property (take && cmd_code == SESC_CMD_IDN_RD
    |-> ##2 resp_valid ##1 resp_valid ##1 resp_valid ##1 (resp_valid && resp_last)) else $error("identity stream wrong");
  chk_recall_abort: assert property (take && cmd_code == SESC_CMD_RECALL
    |=> state_recall && trigger_abort && cal_disable && recall_location == last_data_reg[1:0])
    else $error("recall without abort");
  chk_factory_abort: assert property (take && cmd_code == SESC_CMD_FACTORY
    |=> (factory_load && trigger_abort) ##1 sweep_points == DEF_SWEEP_POINTS) else $error("factory reset wrong");
  cov_done_query: cover property (take && cmd_code == SESC_CMD_OPC_RD);
  cov_identity: cover property (take && cmd_code == SESC_CMD_IDN_RD);
  cov_summary: cover property (event_summary_bit && service_request);
endmodule

bind sesc_status_block sesc_status_chk i_chk (.clock, .rst, .cmd_valid, .cmd_code, .cmd_data, .cmd_ready,
  .resp_valid, .resp_data, .resp_last, .oper_summary, .ques_summary, .msg_available, .nv_write,
  .nv_event_mask_out, .nv_service_mask_out, .nv_powerup_clear_out, .event_summary_bit, .status_byte,
  .service_request, .trigger_abort, .state_recall, .recall_location, .cal_disable, .factory_load, .sweep_points);

// ---- bench/sesc_host.sv ----
// host controller model issuing common commands
`timescale 1ns/100ps
module sesc_host
  import sesc_pkg::*;
(
  input wire logic clock,
  input wire logic cmd_ready,
  output logic cmd_valid,
  output sesc_cmd_t cmd_code,
  output logic cmd_overlap,
  output logic [7:0] cmd_data
);
  initial
  begin
    {cmd_valid, cmd_overlap, cmd_data} = 10'h000;
    cmd_code = SESC_CMD_OTHER;
  end
  // 8-bit argument keeps masks in 0..255
  task automatic send(input sesc_cmd_t c, input logic [7:0] d, input logic o);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_data <= d;
    cmd_overlap <= o;
    @(negedge clock);
    for (int n = 0; !cmd_ready && n < 2000; n++)
      @(negedge clock);
    @(posedge clock);
    // released lines show junk
    cmd_valid <= 1'b0;
    cmd_code <= sesc_cmd_t'(~c);
    cmd_data <= ~d;
    cmd_overlap <= ~o;
  endtask
endmodule

// ---- bench/std_event_status_common_cmds_test.sv ----
// self-checking testbench of the standard event status block
`timescale 1ns/100ps
module std_event_status_common_cmds_test
  import sesc_pkg::*;
;
  logic clock, rst, cmd_valid, cmd_overlap, cmd_ready, resp_valid, resp_last, op_done, trig_busy;
  logic oper_summary, ques_summary, msg_available, nv_powerup_clear, powerup_state_select;
  logic event_summary_bit, service_request, cal_disable, acq_source_internal, tran_source_bus, slope_positive;
  sesc_cmd_t cmd_code;
  logic [3:0] ev;
  logic [7:0] cmd_data, resp_data, nv_event_mask, nv_service_mask, nv_event_mask_out, trigger_count, r;
  logic [15:0] sweep_points, sample_interval_ns, trigger_level, trigger_hyst;
  logic [7:0] exp_q[$];
  int errors = 0, check_count = 0, cycles = 0;
  sesc_host i_host (.clock, .cmd_ready, .cmd_valid, .cmd_code, .cmd_overlap, .cmd_data);
  // identity codes below are arbitrary
  sesc_status_block #(.MAKER_CODE(8'h5a), .MODEL_CODE(8'h63), .FW_REV_CODE(8'h21)) i_dut (.clock, .rst,
    .cmd_valid, .cmd_code, .cmd_overlap, .cmd_data, .cmd_ready,
    .resp_valid, .resp_data, .resp_last, .op_done, .trig_busy, .command_error_flag(ev[3]),
    .execution_error_flag(ev[2]), .device_error_flag(ev[1]), .query_error_flag(ev[0]), .oper_summary,
    .ques_summary, .msg_available, .nv_powerup_clear, .nv_event_mask, .nv_service_mask, .powerup_state_select,
    .nv_write(), .nv_event_mask_out, .nv_service_mask_out(), .nv_powerup_clear_out(), .event_summary_bit,
    .status_byte(), .service_request, .status_clear(), .trigger_abort(), .state_recall(), .recall_location(),
    .cal_disable, .factory_load(), .sweep_points, .sample_interval_ns, .acq_source_internal, .tran_source_bus,
    .slope_positive, .trigger_count, .trigger_level, .trigger_hyst);
  // ***************************************************************
  // clock, timeout, checking
  // ***************************************************************
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      results();
    end
  end
  // sampled mid-cycle, clear of the launching edge
  always @(negedge clock)
  begin
    if (rst === 1'b0 && resp_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        errors++;
        $display("Error at %0t: unexpected answer %h", $time, resp_data);
      end
      else
        check(16'(resp_data), 16'(exp_q.pop_front()));
    end
  end
  task automatic ask(input sesc_cmd_t c, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.send(c, 8'h00, 1'b0);
  endtask
  task automatic drain();
    for (int n = 0; exp_q.size() > 0 && n < 400; n++)
      @(posedge clock);
    if (exp_q.size() > 0)
      check(16'(exp_q.size()), 16'h0000);
    @(posedge clock);
  endtask
  task automatic pulse_ev(input logic [3:0] m);
    @(posedge clock);
    ev <= m;
    @(posedge clock);
    ev <= 4'h0;
  endtask
  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial
  begin
    rst = 1'b1;
    {ev, op_done, trig_busy, oper_summary, ques_summary, msg_available} = 9'h000;
    nv_powerup_clear = 1'b1;
    nv_event_mask = 8'hff;
    nv_service_mask = 8'hff;
    powerup_state_select = 1'b1;
    r = 8'($urandom(32'ha5527c4f));
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    #25;
    check(sweep_points, 16'h0800);
    check(sample_interval_ns, 16'h3cf0);
    check(16'({acq_source_internal, tran_source_bus, slope_positive, trigger_count}), 16'h0701);
    check(trigger_level | trigger_hyst, 16'h0000);
    check(16'(cal_disable), 16'h0001);
    ask(SESC_CMD_ESE_RD, 8'h00);
    ask(SESC_CMD_SRE_RD, 8'h00);
    ask(SESC_CMD_ESR_RD, 8'h80);
    ask(SESC_CMD_ESR_RD, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      r = 8'($urandom);
      {oper_summary, ques_summary, msg_available} <= r[2:0];
      i_host.send(SESC_CMD_ESE_WR, r, 1'b0);
      ask(SESC_CMD_ESE_RD, r & EV_IMPL_MASK);
      pulse_ev(4'h1 << i);
      ask(SESC_CMD_ESR_RD, 8'h04 << i);
    end
    i_host.send(SESC_CMD_ESE_WR, 8'h20, 1'b0);
    pulse_ev(4'hf);
    @(negedge clock);
    check(16'(event_summary_bit), 16'h0001);
    i_host.send(SESC_CMD_ESE_WR, 8'h42, 1'b0);
    @(negedge clock);
    check(16'(event_summary_bit), 16'h0000);
    ask(SESC_CMD_ESR_RD, 8'h3c);
    pulse_ev(4'h4);
    i_host.send(SESC_CMD_CLS, 8'h00, 1'b0);
    ask(SESC_CMD_ESR_RD, 8'h00);
    i_host.send(SESC_CMD_ESE_WR, 8'h01, 1'b0);
    i_host.send(SESC_CMD_OTHER, 8'h00, 1'b1);
    i_host.send(SESC_CMD_OPC, 8'h00, 1'b0);
    #55;
    check(16'(event_summary_bit), 16'h0000);
    @(posedge clock);
    op_done <= 1'b1;
    @(posedge clock);
    op_done <= 1'b0;
    #25;
    check(16'(event_summary_bit), 16'h0001);
    ask(SESC_CMD_ESR_RD, 8'h01);
    @(posedge clock);
    trig_busy <= 1'b1;
    ask(SESC_CMD_OPC_RD, ASCII_ONE);
    #105;
    check(16'(exp_q.size()), 16'h0001);
    @(posedge clock);
    trig_busy <= 1'b0;
    drain();
    exp_q = {exp_q, 8'h5a, 8'h63, 8'h00};
    ask(SESC_CMD_IDN_RD, 8'h21);
    ask(SESC_CMD_OPT_RD, 8'h00);
    i_host.send(SESC_CMD_PSC_WR, 8'h00, 1'b0);
    ask(SESC_CMD_PSC_RD, 8'h00);
    i_host.send(SESC_CMD_ESE_WR, 8'h81, 1'b0);
    i_host.send(SESC_CMD_SRE_WR, 8'h28, 1'b0);
    ask(SESC_CMD_SRE_RD, 8'h28);
    ques_summary <= 1'b1;
    @(negedge clock);
    check(16'({nv_event_mask_out, 7'h00, service_request}), 16'h8101);
    i_host.send(SESC_CMD_RECALL, 8'h02, 1'b0);
    i_host.send(SESC_CMD_FACTORY, 8'h00, 1'b0);
    drain();
    r = 8'($urandom);
    rst <= 1'b1;
    nv_powerup_clear <= 1'b0;
    nv_event_mask <= r;
    nv_service_mask <= 8'h20;
    powerup_state_select <= 1'b0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    #25;
    check(16'({event_summary_bit, cal_disable}), 16'({r[7], 1'b0}));
    ask(SESC_CMD_ESE_RD, r & EV_IMPL_MASK);
    ask(SESC_CMD_SRE_RD, 8'h20);
    ask(SESC_CMD_ESR_RD, 8'h80);
    drain();
    results();
  end
endmodule
